// *** hw/sdp_packer.sv ***
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module sdp_packer #(
  parameter int unsigned CYC_MS = sdp_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // APB slave
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Serial receive bytes
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_valid_in,
  output logic             rx_ready_out,
  // Packet bytes toward the network
  output logic      [7:0]  tx_data_out,
  output logic             tx_valid_out,
  output logic             tx_last_out,
  input  wire logic        tx_ready_in
);
  import sdp_pkg::*;
  typedef enum logic {SDP_COLLECT, SDP_DRAIN} sdp_state_type;
  logic [7:0]       mem [BUF_DEPTH];
  logic [CNT_W-1:0] max_len, next_max_len;
  logic             d1_en, next_d1_en, d2_en, next_d2_en;
  sdp_proc_type     proc_mode, next_proc_mode;
  logic [7:0]       d1, next_d1, d2, next_d2;
  logic [15:0]      gap_ms, next_gap_ms;
  logic [31:0]      next_prdata;
  logic             next_pready, next_pslverr;
  sdp_state_type    state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt, pkt_len, next_pkt_len, rd, next_rd;
  logic [1:0]       pend, next_pend;
  logic             last_d1, next_last_d1;
  logic [15:0]      presc, next_presc, idle_ms, next_idle_ms, pkts, next_pkts;
  logic [7:0]       next_tx_data;
  logic             next_tx_valid, next_tx_last, next_rx_ready;
  logic             acc, delim_on, hit, store, strip2, release_now;
  logic [CNT_W-1:0] cnt_after, rel_len;
  // Register access; answers in the first access cycle
  always_comb
  begin
    next_max_len   = max_len;
    next_d1_en     = d1_en;
    next_d2_en     = d2_en;
    next_proc_mode = proc_mode;
    next_d1        = d1;
    next_d2        = d2;
    next_gap_ms    = gap_ms;
    next_prdata    = prdata_out;
    next_pready    = psel_in && !penable_in;
    next_pslverr   = 1'b0;
    if (psel_in && !penable_in)
    begin
      next_prdata = 32'h0000_0000;
      unique case (paddr_in)
        CTRL_OFS:
        begin
          next_prdata[MAXLEN_LSB +: CNT_W] = max_len;
          next_prdata[D1EN_BIT]            = d1_en;
          next_prdata[D2EN_BIT]            = d2_en;
          next_prdata[PROC_LSB +: 2]       = proc_mode;
        end
        DELIM_OFS:
        begin
          next_prdata[D1_LSB +: 8] = d1;
          next_prdata[D2_LSB +: 8] = d2;
        end
        GAP_OFS:    next_prdata[15:0] = gap_ms;
        STATUS_OFS:
        begin
          next_prdata[COUNT_LSB +: CNT_W] = cnt;
          next_prdata[BUSY_BIT]           = (state == SDP_DRAIN);
          next_prdata[PEND_LSB +: 2]      = pend;
        end
        PKTCNT_OFS: next_prdata[15:0] = pkts;
        default:    next_pslverr = 1'b1;
      endcase
    end
    if (psel_in && penable_in && pready_out && pwrite_in)
    begin
      unique case (paddr_in)
        CTRL_OFS:
        begin
          next_max_len   = pwdata_in[MAXLEN_LSB +: CNT_W];
          next_d1_en     = pwdata_in[D1EN_BIT];
          next_d2_en     = pwdata_in[D2EN_BIT];
          next_proc_mode = sdp_proc_type'(pwdata_in[PROC_LSB +: 2]);
        end
        DELIM_OFS:
        begin
          next_d1 = pwdata_in[D1_LSB +: 8];
          next_d2 = pwdata_in[D2_LSB +: 8];
        end
        GAP_OFS: next_gap_ms = pwdata_in[15:0];
        default: next_gap_ms = gap_ms;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      max_len     <= MAXLEN_RST;
      d1_en       <= 1'b0;
      d2_en       <= 1'b0;
      proc_mode   <= SDP_PROC_PLAIN;
      d1          <= DELIM_RST;
      d2          <= DELIM_RST;
      gap_ms      <= GAP_RST;
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      max_len     <= next_max_len;
      d1_en       <= next_d1_en;
      d2_en       <= next_d2_en;
      proc_mode   <= next_proc_mode;
      d1          <= next_d1;
      d2          <= next_d2;
      gap_ms      <= next_gap_ms;
      prdata_out  <= next_prdata;
      pready_out  <= next_pready;
      pslverr_out <= next_pslverr;
    end
  end
  // Packing engine
  always_comb
  begin
    acc = rx_valid_in && rx_ready_out;
    delim_on = d1_en && (max_len == 11'h000);
    hit = acc && delim_on && (pend == 2'h0)
          && (d2_en ? (last_d1 && rx_data_in == d2) : (rx_data_in == d1));
    strip2    = hit && (proc_mode == SDP_PROC_STRIP) && d2_en;
    store     = acc && !(hit && proc_mode == SDP_PROC_STRIP);
    cnt_after = cnt + CNT_W'(store);
    rel_len   = cnt_after - CNT_W'(strip2);
    release_now = 1'b0;
    next_state    = state;
    next_cnt      = cnt;
    next_pkt_len  = pkt_len;
    next_rd       = rd;
    next_pend     = pend;
    next_last_d1  = last_d1;
    next_presc    = presc;
    next_idle_ms  = idle_ms;
    next_pkts     = pkts;
    next_tx_data  = tx_data_out;
    next_tx_valid = tx_valid_out;
    next_tx_last  = tx_last_out;
    unique case (state)
      SDP_COLLECT:
      begin
        if (acc)
        begin
          next_cnt     = cnt_after;
          next_last_d1 = (rx_data_in == d1);
          next_presc   = 16'h0000;
          next_idle_ms = 16'h0000;
          if (hit && proc_mode == SDP_PROC_PLUS1)
            next_pend = 2'h1;
          else if (hit && proc_mode == SDP_PROC_PLUS2)
            next_pend = 2'h2;
          else if (pend != 2'h0)
            next_pend = pend - 2'h1;
          release_now = (max_len != 11'h000 && cnt_after == max_len)
                        || (hit && (proc_mode == SDP_PROC_PLAIN || proc_mode == SDP_PROC_STRIP))
                        || (pend == 2'h1)
                        || (cnt_after == BUF_DEPTH);
        end
        else if (presc == 16'(CYC_MS - 1))
        begin
          next_presc = 16'h0000;
          if (idle_ms != 16'hFFFF)
            next_idle_ms = idle_ms + 16'h0001;
        end
        else
          next_presc = presc + 16'h0001;
        // idle gap, zero disables it
        // At or past the gap, so a gap lowered mid-packet still releases
        if (!acc && gap_ms != 16'h0000 && cnt != 11'h000 && idle_ms >= gap_ms)
          release_now = 1'b1;
        if (release_now)
        begin
          next_pend    = 2'h0;
          next_last_d1 = 1'b0;
          next_presc   = 16'h0000;
          next_idle_ms = 16'h0000;
          if (rel_len == 11'h000)
            next_cnt = 11'h000;
          else
          begin
            next_state   = SDP_DRAIN;
            next_pkt_len = rel_len;
            next_rd      = 11'h000;
            next_pkts    = pkts + 16'h0001;
          end
        end
      end
      SDP_DRAIN:
      begin
        if (!tx_valid_out || tx_ready_in)
        begin
          if (rd == pkt_len)
          begin
            next_tx_valid = 1'b0;
            next_tx_last  = 1'b0;
            next_state    = SDP_COLLECT;
            next_cnt      = 11'h000;
          end
          else
          begin
            next_tx_data  = mem[rd[CNT_W-2:0]];
            next_tx_valid = 1'b1;
            next_tx_last  = (rd + 11'h001 == pkt_len);
            next_rd       = rd + 11'h001;
          end
        end
      end
    endcase
    // Back-pressure while draining, so no byte is lost
    next_rx_ready = (next_state == SDP_COLLECT);
  end
  always_ff @(posedge mclk_in)
  begin
    if (state == SDP_COLLECT && store && cnt != BUF_DEPTH)
      mem[cnt[CNT_W-2:0]] <= rx_data_in;
  end
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state        <= SDP_COLLECT;
      cnt          <= 11'h000;
      pkt_len      <= 11'h000;
      rd           <= 11'h000;
      pend         <= 2'h0;
      last_d1      <= 1'b0;
      presc        <= 16'h0000;
      idle_ms      <= 16'h0000;
      pkts         <= 16'h0000;
      tx_data_out  <= 8'h00;
      tx_valid_out <= 1'b0;
      tx_last_out  <= 1'b0;
      rx_ready_out <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      cnt          <= next_cnt;
      pkt_len      <= next_pkt_len;
      rd           <= next_rd;
      pend         <= next_pend;
      last_d1      <= next_last_d1;
      presc        <= next_presc;
      idle_ms      <= next_idle_ms;
      pkts         <= next_pkts;
      tx_data_out  <= next_tx_data;
      tx_valid_out <= next_tx_valid;
      tx_last_out  <= next_tx_last;
      rx_ready_out <= next_rx_ready;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence plain_hit_s;
    hit && proc_mode == SDP_PROC_PLAIN && cnt_after != BUF_DEPTH;
  endsequence
  sequence plus2_hit_s;
    hit && proc_mode == SDP_PROC_PLUS2 && cnt < 11'h3F0;
  endsequence
  sequence plus2_first_s;
    plus2_hit_s ##1 acc;
  endsequence
  sequence quiet_byte_s;
    acc && max_len == 11'h000 && pend == 2'h0 && cnt_after < BUF_DEPTH;
  endsequence
  no_limit_a: assert property (quiet_byte_s and !hit |=> state == SDP_COLLECT)
    else $error("length zero released without cause");
  len_hit_a: assert property (acc && max_len != 11'h000 && cnt_after == max_len
    |=> state == SDP_DRAIN && pkt_len == $past(max_len))
    else $error("length limit did not release");
  delim_gate_a: assert property (acc && max_len != 11'h000 && cnt_after != max_len
    && cnt_after != BUF_DEPTH |=> state == SDP_COLLECT)
    else $error("delimiter acted with nonzero length");
  full_rel_a: assert property (acc && cnt_after == BUF_DEPTH
    |=> state == SDP_DRAIN && !rx_ready_out)
    else $error("full buffer not released");
  plain_rel_a: assert property (plain_hit_s
    |=> state == SDP_DRAIN && pkt_len == $past(cnt) + 11'h001)
    else $error("plain delimiter release wrong");
  plus_two_a: assert property (plus2_first_s |=> state == SDP_COLLECT && pend == 2'h1)
    else $error("plus-two released early");
  strip_len_a: assert property (hit && proc_mode == SDP_PROC_STRIP && cnt > 11'(d2_en)
    |=> pkt_len == $past(cnt) - 11'($past(d2_en)))
    else $error("strip length wrong");
  pair_need_a: assert property (quiet_byte_s and (d1_en && d2_en && !last_d1)
    |=> state == SDP_COLLECT)
    else $error("single delimiter released a pair");
  no_option_a: assert property (quiet_byte_s and !d1_en
    |=> state == SDP_COLLECT && pend == 2'h0)
    else $error("option acted without first delimiter");
  gap_rel_a: assert property (state == SDP_COLLECT && !acc && gap_ms != 16'h0000
    && cnt != 11'h000 && idle_ms == gap_ms |=> state == SDP_DRAIN)
    else $error("idle gap did not release");
  gap_off_a: assert property (state == SDP_COLLECT && !acc && gap_ms == 16'h0000
    |=> state == SDP_COLLECT)
    else $error("idle release with gap zero");
endmodule // sdp_packer

// *** hw/sdp_pkg.sv ***
package sdp_pkg;
  // Clock rate and the idle-gap time base
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned GAP_UNIT_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / GAP_UNIT_S;

  // Buffer size, also the 1 KB ceiling
  localparam int unsigned      CNT_W     = 11;
  localparam logic [CNT_W-1:0] BUF_DEPTH = 11'h400;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] DELIM_OFS  = 8'h04;
  localparam logic [7:0] GAP_OFS    = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] PKTCNT_OFS = 8'h10;

  // Control field positions
  localparam int unsigned MAXLEN_LSB = 0;
  localparam int unsigned D1EN_BIT   = 16;
  localparam int unsigned D2EN_BIT   = 17;
  localparam int unsigned PROC_LSB   = 20;
  // Delimiter field positions
  localparam int unsigned D1_LSB     = 0;
  localparam int unsigned D2_LSB     = 8;
  // Status field positions
  localparam int unsigned COUNT_LSB  = 0;
  localparam int unsigned BUSY_BIT   = 16;
  localparam int unsigned PEND_LSB   = 20;

  // Values after reset
  localparam logic [CNT_W-1:0] MAXLEN_RST = 11'h000;
  localparam logic [7:0]       DELIM_RST  = 8'h00;
  localparam logic [15:0]      GAP_RST    = 16'h0000;

  // Delimiter handling option
  typedef enum logic [1:0] {
    SDP_PROC_PLAIN,
    SDP_PROC_PLUS1,
    SDP_PROC_PLUS2,
    SDP_PROC_STRIP
  } sdp_proc_type;
endpackage

// *** tb/sdp_net_sink.sv ***
`timescale 1ns/100ps
module sdp_net_sink (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  // Network side handshake
  output logic      tx_ready_out
);
  int seed = 96768;

  // Random stalls make the packer hold each byte until it is taken
  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
      tx_ready_out <= 1'b0;
    else
      tx_ready_out <= ($random(seed) & 3) != 0;
endmodule // sdp_net_sink

// *** tb/tb_serial_data_packer.sv ***
`timescale 1ns/100ps
module tb_serial_data_packer;
  import sdp_pkg::*;
  logic        mclk_in, rst_n_in, psel, penable, pwrite, rx_valid;
  logic        pready, pslverr, rx_ready, tx_valid, tx_last, tx_ready, rerr;
  logic [7:0]  paddr, rx_data, tx_data;
  logic [31:0] pwdata, prdata, rdat;
  logic [8:0]  exp_q[$];
  int          bad_count = 0;
  int          cmp_count = 0;
  int          seed = 96768;
  int          n, k;

  sdp_packer #(.CYC_MS(4)) dut_u (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .rx_data_in(rx_data), .rx_valid_in(rx_valid),
    .rx_ready_out(rx_ready), .tx_data_out(tx_data), .tx_valid_out(tx_valid),
    .tx_last_out(tx_last), .tx_ready_in(tx_ready));

  sdp_net_sink sink_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .tx_ready_out(tx_ready));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    end_of_test();
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Payload bytes never collide with the delimiters in use
  function automatic logic [7:0] rnd();
    return 8'h40 | 8'($random(seed) & 32'h3F);
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge mclk_in);
      if (pready === 1'b1)
        break;
    end
    rdat = prdata;
    rerr = pslverr;
    if (i == 20)
      hang();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_in);
  endtask

  // m[0]: byte expected in a packet, m[1]: expected as its last byte
  task automatic put(input logic [7:0] b, input logic [1:0] m);
    int i;
    if (m[0])
      exp_q.push_back({m[1], b});
    rx_valid <= 1'b1;
    rx_data <= b;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge mclk_in);
      if (rx_ready === 1'b1)
        break;
    end
    if (i == 3000)
      hang();
  endtask

  task automatic drain();
    int i;
    rx_valid <= 1'b0;
    for (i = 0; i < 5000 && exp_q.size() != 0; i++)
      @(posedge mclk_in);
    if (i == 5000)
      hang();
    repeat (3) @(posedge mclk_in);
  endtask

  always @(posedge mclk_in)
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("extra tx byte", 32'h1, 32'h0);
      else
        check("tx byte", {23'h0, tx_last, tx_data}, {23'h0, exp_q.pop_front()});
    end

  initial
  begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  initial
  begin
    repeat (100000) @(posedge mclk_in);
    hang();
  end

  initial
  begin
    {rst_n_in, psel, penable, pwrite, rx_valid} = 5'h00;
    {paddr, rx_data, pwdata} = 48'h0;
    repeat (6) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    apb(1'b0, CTRL_OFS, 32'h0);
    check("ctrl reset", rdat, 32'h0);
    apb(1'b0, GAP_OFS, 32'h0);
    check("gap reset", rdat, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped err", {31'h0, rerr}, 32'h1);
    check("unmapped data", rdat, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h3);
    for (k = 0; k < 6; k++)
      put(rnd(), k % 3 == 2 ? 2'b11 : 2'b01);
    drain();
    apb(1'b1, DELIM_OFS, 32'h0A0D);
    for (n = 0; n < 4; n++)
    begin
      apb(1'b1, CTRL_OFS, (32'(n) << PROC_LSB) | (32'h1 << D1EN_BIT));
      put(rnd(), n == 3 ? 2'b11 : 2'b01);
      put(8'h0D, n == 0 ? 2'b11 : n == 3 ? 2'b00 : 2'b01);
      for (k = 1; k <= n && n < 3; k++)
        put(rnd(), k == n ? 2'b11 : 2'b01);
      drain();
    end
    // first delimiter alone holds, the pair releases
    apb(1'b1, CTRL_OFS, (32'h1 << D1EN_BIT) | (32'h1 << D2EN_BIT));
    put(rnd(), 2'b01);
    put(8'h0D, 2'b01);
    put(rnd(), 2'b01);
    put(8'h0D, 2'b01);
    put(8'h0A, 2'b11);
    drain();
    apb(1'b1, CTRL_OFS, (32'(SDP_PROC_STRIP) << PROC_LSB) | (32'h3 << D1EN_BIT));
    put(rnd(), 2'b11);
    put(8'h0D, 2'b00);
    put(8'h0A, 2'b00);
    drain();
    apb(1'b1, CTRL_OFS, (32'h1 << D1EN_BIT) | 32'h2);
    put(8'h0D, 2'b01);
    put(rnd(), 2'b11);
    drain();
    // strip option inert, idle gap releases
    apb(1'b1, GAP_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, 32'(SDP_PROC_STRIP) << PROC_LSB);
    put(rnd(), 2'b01);
    put(8'h0D, 2'b11);
    drain();
    apb(1'b1, GAP_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h1 << D1EN_BIT);
    put(rnd(), 2'b01);
    rx_valid <= 1'b0;
    repeat (50) @(posedge mclk_in);
    for (k = 1; k < 1024; k++)
      put(rnd(), k == 1023 ? 2'b11 : 2'b01);
    drain();
    apb(1'b0, PKTCNT_OFS, 32'h0);
    check("packet count", {16'h0, rdat[15:0]}, 32'hB);
    apb(1'b0, STATUS_OFS, 32'h0);
    check("buffered count", {21'h0, rdat[10:0]}, 32'h0);
    end_of_test();
  end
endmodule // tb_serial_data_packer
